// ---- core/dpsr_map.vh ----
// Constants for the DRAM power-state and refresh controller
`ifndef DPSR_MAP_VH
`define DPSR_MAP_VH
// Row command codes presented on the row command port
`define DPSR_CMD_W 3
`define DPSR_CMD_NONE 3'h0
`define DPSR_CMD_DOZE 3'h1
`define DPSR_CMD_DEEP 3'h2
`define DPSR_CMD_DOZE_REL 3'h3
`define DPSR_CMD_DEEP_REL 3'h4
`define DPSR_CMD_ACT 3'h5
`define DPSR_CMD_PRE 3'h6
// Refresh bank sequence bounds
`define DPSR_FIRST_BANK 5'h0c
`define DPSR_LAST_BANK 5'h1f
// Default timing counts in clock cycles
`define DPSR_CLK_HOLD 16
`define DPSR_QUIET 16
`define DPSR_PRE_EXIT 16
`define DPSR_LOCKOUT 32
`define DPSR_RAS 16
`define DPSR_REF_INT 1953
`define DPSR_BURST_GAP 8
`define DPSR_DOZE_MAX 100000
`endif

// ---- core/dpsr_ctrl.v ----
// Host-side controller for DRAM low-power entry, wake-up and periodic refresh
// Summary of operation
// (R1) Doze or deep-sleep entry sent as a row command to the device.
// (R2) Channel clock held stable for clock-hold time after entry command.
// (R3) Device returns to attention or idle-ready state held at entry.
// (R4) Device restores output current and slew levels leaving deep-sleep.
// (R5) Write buffer retired and banks precharged before entry; user sequences this.
// (R6) No packets to the device during the quiet interval after entry.
// (R7) Channel clocks stable for pre-exit interval before wake starts.
// (R8) Wake pattern 01 on command pin across serial clock fall then rise.
// (R9) Serial input low for doze exit, high for deep-sleep exit at fall.
// (R10) Device identifier on lane A low bits at slot-selected rising edge.
// (R11) With bypass set, device ignores identifier and wakes on pattern.
// (R12) Row and column quiet around wake edge before directing packets.
// (R13) Lockouts after exit before re-entry and after entry before exit.
// (R14) Broadcast periodic activate opens bank at device row counter row.
// (R15) Device advances row counter when maximum bank is activated.
// (R16) Periodic activates issued once per refresh interval on average.
// (R17) Broadcast periodic precharge issued one row-active time after activate.
// (R18) Refresh banks stepped non-adjacently starting at 12, ending at 31.
// (R19) Device self-refreshes in deep-sleep and in doze with enable set.
// (R20) Device self-refresh uses internal time base and counters.
// (R21) Refresh up to bank 31 before sleep, restart from bank 12 after.
// (R22) All banks refreshed once in burst interval after exit.
// (R23) Release command returns attention states to idle-ready.
// (R24) Doze stay limited to maximum doze time, then forced wake.
// (R25) Device records entry state and release request for exit.
// (R26) Refresh continues while doze has self-refresh disabled.
`timescale 1ns/100ps
`include "dpsr_map.vh"
module dpsr_ctrl #(
	parameter CLK_HOLD = `DPSR_CLK_HOLD,
	parameter QUIET = `DPSR_QUIET,
	parameter PRE_EXIT = `DPSR_PRE_EXIT,
	parameter LOCKOUT = `DPSR_LOCKOUT,
	parameter RAS = `DPSR_RAS,
	parameter REF_INT = `DPSR_REF_INT,
	parameter BURST_GAP = `DPSR_BURST_GAP,
	parameter DOZE_MAX = `DPSR_DOZE_MAX,
	parameter SCK_DIV = 8
)(
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// User orders
	input wire sleep_req_i,
	input wire sleep_deep_i,
	input wire sleep_release_i,
	input wire wake_req_i,
	input wire [5:0] exit_device_identifier_i,
	input wire exit_device_select_bypass_i,
	input wire exit_slot_i,
	input wire doze_self_renewal_enable_i,
	// Status
	output reg busy_o,
	output reg asleep_o,
	output reg row_quiet_o,
	// Row command port toward channel packet logic
	output reg [2:0] row_cmd_o,
	output reg [4:0] row_bank_o,
	output reg row_broadcast_o,
	output reg clock_hold_o,
	// Wake pins
	output reg wake_cmd_o,
	output reg serial_input_pin_o,
	output reg serial_clk_o,
	output reg [5:0] data_lane_a_low_bits_o,
	output reg data_lane_a_oe_o
);
	// ==============================
	// Helpers
	function [4:0] next_bank;
		input [4:0] b;
		begin
			// Fixed table order inside each half keeps neighbours apart; f moves on to the other half
			case (b[3:0])
				4'hc: next_bank = {b[4], 4'ha};
				4'ha: next_bank = {b[4], 4'h5};
				4'h5: next_bank = {b[4], 4'h3};
				4'h3: next_bank = {b[4], 4'h0};
				4'h0: next_bank = {b[4], 4'he};
				4'he: next_bank = {b[4], 4'h9};
				4'h9: next_bank = {b[4], 4'h7};
				4'h7: next_bank = {b[4], 4'h4};
				4'h4: next_bank = {b[4], 4'h2};
				4'h2: next_bank = {b[4], 4'hd};
				4'hd: next_bank = {b[4], 4'hb};
				4'hb: next_bank = {b[4], 4'h8};
				4'h8: next_bank = {b[4], 4'h6};
				4'h6: next_bank = {b[4], 4'h1};
				4'h1: next_bank = {b[4], 4'hf};
				default: next_bank = {~b[4], 4'hc};
			endcase
		end
	endfunction
	// ==============================
	// States
	localparam S_AWAKE = 4'h0;
	localparam S_DRAIN = 4'h1;
	localparam S_ENTER = 4'h2;
	localparam S_HOLD = 4'h3;
	localparam S_SLEEP = 4'h4;
	localparam S_PREX = 4'h5;
	localparam S_WFALL = 4'h6;
	localparam S_WRISE = 4'h7;
	localparam S_WID = 4'h8;
	localparam S_LOCK = 4'h9;
	reg [3:0] state_reg;
	reg [31:0] tmr_reg;
	reg [31:0] ref_tmr_reg;
	reg [31:0] ras_tmr_reg;
	reg [31:0] doze_tmr_reg;
	reg [4:0] bank_reg;
	reg ras_pend_reg;
	reg deep_reg;
	reg self_ref_reg;
	reg burst_reg;
	reg [5:0] burst_cnt_reg;
	reg [1:0] sck_ph_reg;
	reg slot_reg;
	reg fire_act;
	wire ref_due = burst_reg ? (ref_tmr_reg >= BURST_GAP) : (ref_tmr_reg >= REF_INT);
	// Quiet and wake windows carry no new activate, even while the core is not self-refreshing
	wire quiet_state = state_reg == S_HOLD || state_reg == S_PREX || state_reg == S_WFALL
		|| state_reg == S_WRISE || state_reg == S_WID || state_reg == S_LOCK; // see (R6)
	wire refresh_live = !quiet_state && (!self_ref_reg || (state_reg != S_SLEEP && state_reg != S_ENTER));
	wire sck_tick = (tmr_reg >= SCK_DIV - 1);
	always @*
	begin
		fire_act = refresh_live && ref_due && !ras_pend_reg && state_reg != S_ENTER;
	end
	// ==============================
	// Main sequencer
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_reg <= S_AWAKE;
			tmr_reg <= 32'h0;
			ref_tmr_reg <= 32'h0;
			ras_tmr_reg <= 32'h0;
			doze_tmr_reg <= 32'h0;
			bank_reg <= `DPSR_FIRST_BANK;
			ras_pend_reg <= 1'b0;
			deep_reg <= 1'b0;
			self_ref_reg <= 1'b0;
			burst_reg <= 1'b0;
			burst_cnt_reg <= 6'h0;
			sck_ph_reg <= 2'h0;
			slot_reg <= 1'b0;
			busy_o <= 1'b0;
			asleep_o <= 1'b0;
			row_quiet_o <= 1'b0;
			row_cmd_o <= `DPSR_CMD_NONE;
			row_bank_o <= 5'h0;
			row_broadcast_o <= 1'b0;
			clock_hold_o <= 1'b0;
			wake_cmd_o <= 1'b0;
			serial_input_pin_o <= 1'b0;
			serial_clk_o <= 1'b1;
			data_lane_a_low_bits_o <= 6'h0;
			data_lane_a_oe_o <= 1'b0;
		end
		else
		begin
			row_cmd_o <= `DPSR_CMD_NONE;
			row_broadcast_o <= 1'b0;
			tmr_reg <= tmr_reg + 32'h1;
			ref_tmr_reg <= ref_tmr_reg + 32'h1;
			// Refresh engine
			if (ras_pend_reg)
			begin
				ras_tmr_reg <= ras_tmr_reg + 32'h1;
				if (ras_tmr_reg >= RAS - 1)
				begin
					ras_pend_reg <= 1'b0;
					row_cmd_o <= `DPSR_CMD_PRE; // see (R17)
					row_broadcast_o <= 1'b1;
					row_bank_o <= bank_reg;
					bank_reg <= next_bank(bank_reg); // see (R18)
				end
			end
			else if (fire_act)
			begin
				ref_tmr_reg <= 32'h0; // see (R16)
				ras_pend_reg <= 1'b1;
				ras_tmr_reg <= 32'h0;
				row_cmd_o <= `DPSR_CMD_ACT; // see (R26)
				row_broadcast_o <= 1'b1;
				row_bank_o <= bank_reg;
				if (burst_reg)
				begin
					burst_cnt_reg <= burst_cnt_reg + 6'h1;
					if (burst_cnt_reg == 6'h1f)
						burst_reg <= 1'b0; // see (R22)
				end
			end
			case (state_reg)
				S_AWAKE:
				begin
					busy_o <= 1'b0;
					row_quiet_o <= 1'b0;
					if (sleep_req_i)
					begin
						busy_o <= 1'b1;
						deep_reg <= sleep_deep_i;
						self_ref_reg <= sleep_deep_i | doze_self_renewal_enable_i;
						state_reg <= S_DRAIN;
					end
				end
				S_DRAIN:
				begin
					// Refresh up to the last bank first so self-refresh skips nothing
					if (!self_ref_reg || (bank_reg == `DPSR_FIRST_BANK && !ras_pend_reg && !fire_act))
						state_reg <= S_ENTER; // see (R21)
				end
				S_ENTER:
				begin
					if (!ras_pend_reg)
					begin
						row_cmd_o <= deep_reg ? (sleep_release_i ? `DPSR_CMD_DEEP_REL : `DPSR_CMD_DEEP)
							: (sleep_release_i ? `DPSR_CMD_DOZE_REL : `DPSR_CMD_DOZE); // see (R1)
						row_bank_o <= 5'h0;
						clock_hold_o <= 1'b1; // see (R2)
						row_quiet_o <= 1'b1; // see (R6)
						tmr_reg <= 32'h0;
						state_reg <= S_HOLD;
					end
				end
				S_HOLD:
				begin
					if (tmr_reg >= CLK_HOLD - 1 && tmr_reg >= QUIET - 1 && tmr_reg >= LOCKOUT - 1)
					begin
						clock_hold_o <= 1'b0;
						asleep_o <= 1'b1;
						doze_tmr_reg <= 32'h0;
						state_reg <= S_SLEEP; // see (R13)
					end
				end
				S_SLEEP:
				begin
					doze_tmr_reg <= doze_tmr_reg + 32'h1;
					if (wake_req_i || (!deep_reg && doze_tmr_reg >= DOZE_MAX - 1)) // see (R24)
					begin
						clock_hold_o <= 1'b1; // see (R7)
						tmr_reg <= 32'h0;
						state_reg <= S_PREX;
					end
				end
				S_PREX:
				begin
					if (tmr_reg >= PRE_EXIT - 1)
					begin
						wake_cmd_o <= 1'b0;
						serial_input_pin_o <= deep_reg; // see (R9)
						slot_reg <= exit_slot_i;
						tmr_reg <= 32'h0;
						state_reg <= S_WFALL;
					end
				end
				S_WFALL:
				begin
					if (sck_tick)
					begin
						serial_clk_o <= 1'b0; // see (R8)
						tmr_reg <= 32'h0;
						sck_ph_reg <= 2'h0;
						state_reg <= S_WRISE;
					end
				end
				S_WRISE:
				begin
					if (sck_tick)
					begin
						serial_clk_o <= 1'b1;
						wake_cmd_o <= 1'b1; // see (R8)
						if (!exit_device_select_bypass_i && !slot_reg)
						begin
							data_lane_a_low_bits_o <= exit_device_identifier_i; // see (R10)
							data_lane_a_oe_o <= 1'b1;
						end
						tmr_reg <= 32'h0;
						state_reg <= S_WID;
					end
				end
				S_WID:
				begin
					// Toggle serial clock for two more cycles; second rise serves slot one
					if (sck_tick)
					begin
						tmr_reg <= 32'h0;
						sck_ph_reg <= sck_ph_reg + 2'h1;
						serial_clk_o <= ~serial_clk_o;
						wake_cmd_o <= 1'b0;
						if (sck_ph_reg == 2'h1 && slot_reg && !exit_device_select_bypass_i)
						begin
							data_lane_a_low_bits_o <= exit_device_identifier_i; // see (R10)
							data_lane_a_oe_o <= 1'b1;
						end
						if (sck_ph_reg == 2'h3)
						begin
							data_lane_a_oe_o <= 1'b0;
							clock_hold_o <= 1'b0;
							state_reg <= S_LOCK;
						end
					end
				end
				S_LOCK:
				begin
					asleep_o <= 1'b0;
					// Rows stay quiet through the lockout, then the bank burst starts if the device was self-refreshing
					if (tmr_reg >= LOCKOUT - 1)
					begin
						row_quiet_o <= 1'b0; // see (R12)
						bank_reg <= self_ref_reg ? `DPSR_FIRST_BANK : bank_reg;
						burst_reg <= self_ref_reg; // see (R22)
						burst_cnt_reg <= 6'h0;
						ref_tmr_reg <= BURST_GAP;
						self_ref_reg <= 1'b0;
						state_reg <= S_AWAKE; // see (R13)
					end
				end
				default: state_reg <= S_AWAKE;
			endcase
		end
	end
endmodule // dpsr_ctrl

// ---- bench/dpsr_dev_model.sv ----
// Behavioural memory device at the far end of the controller
`timescale 1ns/100ps
`include "dpsr_map.vh"
module dpsr_dev_model #(
	parameter [5:0] MY_ID = 6'h2a // Arbitrary device number
)(
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Row packets and wake pins
	input wire [2:0] cmd_i,
	input wire [4:0] bank_i,
	input wire wcmd_i,
	input wire sio_i,
	input wire sck_i,
	input wire [5:0] lane_i,
	input wire oe_i,
	// Device settings
	input wire nsr_i,
	input wire byp_i,
	input wire slot_i,
	// Observed state
	output reg asleep_o,
	output reg self_ref_o,
	output reg err_o,
	output reg [7:0] rows_o
);
	// Bank order one nibble a step; the second half adds 16
	localparam [63:0] ORDER = 64'hf168bd2479e035ac;
	reg sq, c0, s0, ok, deep_reg, rel_reg;
	reg [2:0] n;
	reg [4:0] idx;
	// Serial clock is sampled, so edges show one cycle late with data settled
	wire rise = ~sq & sck_i;
	wire pat = (n == 3'h1) ? ~c0 & wcmd_i : ok;
	wire sel = byp_i | (oe_i & lane_i == MY_ID);
	wire hit = asleep_o & rise & n == {1'b0, slot_i, 1'b1} & pat & sel;
	wire act = cmd_i == `DPSR_CMD_ACT;
	wire deep = cmd_i == `DPSR_CMD_DEEP || cmd_i == `DPSR_CMD_DEEP_REL;
	wire [4:0] want = {idx[4], ORDER[{idx[3:0], 2'b00} +: 4]};
	always @(posedge clock_i)
	begin
		sq <= rst_i | sck_i;
		if (rst_i)
			{asleep_o, self_ref_o, err_o, n, idx, rows_o} <= 0;
		else
		begin
			if (cmd_i >= `DPSR_CMD_DOZE && cmd_i <= `DPSR_CMD_DEEP_REL)
			begin
				{asleep_o, n, deep_reg} <= {1'b1, 3'h0, deep};
				rel_reg <= cmd_i >= `DPSR_CMD_DOZE_REL;
				self_ref_o <= deep | nsr_i;
			end
			else if (asleep_o & (sq ^ sck_i))
				n <= n + 3'h1;
			if (asleep_o & sq & ~sck_i & n == 3'h0)
				{c0, s0} <= {wcmd_i, sio_i};
			if (rise & n == 3'h1)
				ok <= ~c0 & wcmd_i;
			if (hit)
				{asleep_o, self_ref_o} <= 2'b00;
			if (act)
				idx <= idx + 5'h01;
			if (act & bank_i == `DPSR_LAST_BANK)
				rows_o <= rows_o + 8'h01;
			err_o <= err_o | (hit & s0 != deep_reg) | (act & bank_i != want);
		end
	end
endmodule // dpsr_dev_model

// ---- bench/dpsr_ctrl_assertions.sv ----
// Port-level checks for the power-state and refresh controller
`timescale 1ns/100ps
`include "dpsr_map.vh"
module dpsr_ctrl_assertions #(
	parameter int RAS = 16
)(
	// Clock, reset and wake settings
	input wire clock_i,
	input wire rst_i,
	input wire [5:0] exit_device_identifier_i,
	input wire exit_device_select_bypass_i,
	input wire exit_slot_i,
	// Controller outputs
	input wire [2:0] row_cmd_o,
	input wire [4:0] row_bank_o,
	input wire row_broadcast_o,
	input wire clock_hold_o,
	input wire wake_cmd_o,
	input wire serial_input_pin_o,
	input wire serial_clk_o,
	input wire [5:0] data_lane_a_low_bits_o,
	input wire data_lane_a_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ========================================
	// Helpers
	wire entry = row_cmd_o >= `DPSR_CMD_DOZE && row_cmd_o <= `DPSR_CMD_DEEP_REL;
	wire act = row_cmd_o == `DPSR_CMD_ACT;
	wire none = row_cmd_o == `DPSR_CMD_NONE;
	reg deep_reg = 1'b0;
	reg [4:0] bank_reg = 5'h00;
	reg armed_reg = 1'b0;
	reg sck_q = 1'b1;
	always @(posedge clock_i)
	begin
		sck_q <= serial_clk_o;
		// Armed by an entry command, spent by the first serial clock fall after it
		armed_reg <= entry | (armed_reg & ~(sck_q & ~serial_clk_o));
		deep_reg <= entry ? row_cmd_o == `DPSR_CMD_DEEP || row_cmd_o == `DPSR_CMD_DEEP_REL : deep_reg;
		bank_reg <= act ? row_bank_o : bank_reg;
	end
	// First serial clock fall of a wake, before the command pin goes high
	sequence first_fall;
		$fell(serial_clk_o) && armed_reg && !$past(wake_cmd_o);
	endsequence
	// ========================================
	// Properties
	chk_entry_hold: assert property (entry |=> clock_hold_o [*8] ##1 clock_hold_o [*8])
		else $error("clock hold dropped");
	chk_entry_quiet: assert property (entry |=> none [*8] ##1 none [*7])
		else $error("packet in quiet window");
	chk_wake_edges: assert property (first_fall |-> !wake_cmd_o ##8 ($rose(serial_clk_o) && wake_cmd_o))
		else $error("wake pattern wrong");
	chk_sio_level: assert property (first_fall |-> serial_input_pin_o == deep_reg)
		else $error("serial input level wrong");
	chk_id_slot: assert property ($rose(serial_clk_o) && wake_cmd_o && !exit_slot_i
		&& !exit_device_select_bypass_i |-> data_lane_a_oe_o && data_lane_a_low_bits_o == exit_device_identifier_i)
		else $error("device number missing");
	chk_pre_exit: assert property (first_fall |-> clock_hold_o && $past(clock_hold_o, 16))
		else $error("clock not held before wake");
	chk_act_pre: assert property (act |-> row_broadcast_o
		##RAS (row_cmd_o == `DPSR_CMD_PRE && row_broadcast_o && row_bank_o == $past(row_bank_o, RAS)))
		else $error("precharge missing");
	chk_bank_wrap: assert property (act && bank_reg == `DPSR_LAST_BANK |-> row_bank_o == `DPSR_FIRST_BANK)
		else $error("bank order wrong");
	cover property (entry);
	cover property (first_fall);
	cover property (act && row_bank_o == `DPSR_LAST_BANK);
endmodule // dpsr_ctrl_assertions

// ---- bench/dpsr_ctrl_tb.sv ----
// Self-checking bench for the power-state and refresh controller
`timescale 1ns/100ps
`include "dpsr_map.vh"
module dpsr_ctrl_tb;
	// ========================================
	// Signals
	reg clock_i = 1'b0, rst_i = 1'b1, sleep_req_i = 1'b0, sleep_deep_i = 1'b0, sleep_release_i = 1'b0, wk = 1'b0;
	reg wake_req_i = 1'b0, exit_device_select_bypass_i = 1'b0, exit_slot_i = 1'b0, doze_self_renewal_enable_i = 1'b0;
	reg [5:0] exit_device_identifier_i = 6'h00;
	wire busy_o, asleep_o, row_quiet_o, row_broadcast_o, clock_hold_o, wake_cmd_o, serial_input_pin_o, serial_clk_o;
	wire data_lane_a_oe_o, dev_asleep, dev_sr, dev_err;
	wire [2:0] row_cmd_o;
	wire [4:0] row_bank_o;
	wire [5:0] data_lane_a_low_bits_o;
	wire [7:0] dev_rows;
	reg [7:0] rows_reg;
	int miscompares = 0, tests_run = 0, acts = 0, a0 = 0, k, c;
	// Forced doze wake, deep slot 0, self-renewing doze with bypass, deep with release
	localparam bit [11:0] CASES [4] = '{12'h4aa, 12'h86a, 12'h3d5, 12'hcea};
	// ========================================
	// Design and device
	dpsr_ctrl #(.REF_INT(50), .DOZE_MAX(200)) i_dut (.*);
	dpsr_dev_model i_dev (.clock_i, .rst_i, .cmd_i(row_cmd_o), .bank_i(row_bank_o), .wcmd_i(wake_cmd_o),
		.sio_i(serial_input_pin_o), .sck_i(serial_clk_o), .lane_i(data_lane_a_low_bits_o), .oe_i(data_lane_a_oe_o),
		.nsr_i(doze_self_renewal_enable_i), .byp_i(exit_device_select_bypass_i), .slot_i(exit_slot_i),
		.asleep_o(dev_asleep), .self_ref_o(dev_sr), .err_o(dev_err), .rows_o(dev_rows));
	initial forever #2 clock_i = ~clock_i;
	always @(posedge clock_i) acts <= acts + (asleep_o === 1'b1 && row_cmd_o === `DPSR_CMD_ACT);
	task step;
		@(posedge clock_i);
		#1;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Loop bounds keep the run under 29000 cycles; the 50000-cycle limit leaves ample margin
	initial
	begin
		#200000;
		miscompares++;
		report_and_stop;
	end
	// ========================================
	// Tests
	initial
	begin
		repeat (2) step;
		rst_i = 1'b0;
		for (k = 0; k < 2000 && dev_rows !== 8'h01; k++) step;
		chk(k > 1500 && k < 1700, 1'b1);
		chk(dev_rows, 8'h01);
		for (c = 0; c < 4; c++)
		begin
			{sleep_deep_i, sleep_release_i, doze_self_renewal_enable_i, exit_device_select_bypass_i, exit_slot_i, wk,
				exit_device_identifier_i} = CASES[c];
			sleep_req_i = 1'b1;
			for (k = 0; k < 3000 && asleep_o !== 1'b1; k++) step;
			sleep_req_i = 1'b0;
			a0 = acts;
			chk(dev_asleep, 1'b1);
			chk(busy_o, 1'b1);
			chk(dev_sr, sleep_deep_i | doze_self_renewal_enable_i);
			wake_req_i = wk;
			for (k = 0; k < 3000 && asleep_o !== 1'b0; k++) step;
			wake_req_i = 1'b0;
			chk(k < 600, 1'b1);
			chk(acts != a0, !(sleep_deep_i | doze_self_renewal_enable_i));
			chk(dev_asleep, 1'b0);
			chk(row_quiet_o, 1'b1);
			rows_reg = dev_rows;
			if (sleep_deep_i | doze_self_renewal_enable_i)
			begin
				for (k = 0; k < 700 && dev_rows === rows_reg; k++) step;
				chk(k < 700, 1'b1);
			end
			chk(dev_err, 1'b0);
		end
		report_and_stop;
	end
endmodule // dpsr_ctrl_tb
bind dpsr_ctrl dpsr_ctrl_assertions #(.RAS(RAS)) i_chk (.*);
